// file: hw/sfp_pkg.sv
package sfp_pkg;
  // Clock rates and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 80;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // Array geometry: sector / page / byte
  localparam int SECTORS = 32;
  localparam int PAGES_PER_SECTOR = 256;
  localparam int PAGE_BYTES = 256;
  localparam int PAGES_TOTAL = SECTORS * PAGES_PER_SECTOR;
  localparam int ADDR_W = $clog2(PAGES_TOTAL * PAGE_BYTES);
  localparam int SECT_LSB = 16;
  localparam int PAGE_LSB = 8;
  localparam logic [5:0] SECT_NONE = 6'h20;
  localparam logic [8:0] PROG_MAX = 9'h100;
  localparam logic [1:0] ADDR_LAST = 2'h2;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_STATUS = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG = 8'h12;
  localparam logic [7:0] OP_READ = 8'h13;
  localparam logic [7:0] OP_READ_STATUS = 8'h14;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h15;
  localparam logic [7:0] OP_BULK_ERASE = 8'h16;

  // Reset values; pin order {sclk, cs_b, mosi, hold_b, wp_b}
  localparam logic [4:0] PIN_RESET = 5'h03;
  localparam logic [2:0] BP_RESET = 3'h0;

  // Master-side byte queue
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DATA, PH_IGNORE} sfp_phase_t;
  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_WAIT, HS_END, HS_GAP} sfp_host_st_t;
endpackage

// file: hw/sfp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sfp_link_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic hold_b;
  logic wp_b;
  logic miso;
  logic miso_oe;
  wire miso_line;

  // Pull-up on the shared data-out line when nobody drives it
  assign miso_line = miso_oe ? miso : 1'b1;

  modport flash (input sclk, input cs_b, input mosi, input hold_b, input wp_b, output miso, output miso_oe);
  modport master (output sclk, output cs_b, output mosi, output hold_b, output wp_b, input miso_line);
endinterface
`default_nettype wire

// file: hw/sfp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sfp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push;
  wire pop;
  wire [AW:0] next_count;

  // Handshakes and occupancy; DEPTH must be a power of two
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_out = mem[rd_ptr];

  // Flags are registered so that ready and valid come from flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_out <= next_count != (AW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// file: hw/sfp_master_end.sv
`timescale 1ns/100ps
`default_nettype none
module sfp_master_end (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cpol_in,
  input wire logic hold_req_in,
  input wire logic wp_b_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic busy_out,
  sfp_link_if.master link
);
  import sfp_pkg::*;

  sfp_host_st_t st;
  logic m1;
  logic m2;
  logic [3:0] tmr;
  logic [2:0] bit_idx;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic last;
  wire [FIFO_W-1:0] f_data;
  wire f_valid;
  wire grab;
  wire tmr_end;

  // Byte queue; a slow producer stalls the clock with it low
  sfp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_sfp_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .in_data_in({tx_last_in, tx_data_in}),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(f_data),
    .out_valid_out(f_valid),
    .out_ready_in(grab)
  );

  // Next byte taken only at frame start, clock at its idle level, or between bytes, clock low
  assign grab = f_valid & ((st == HS_IDLE) | ((st == HS_WAIT) & link.hold_b));
  assign tmr_end = tmr == 4'h1;

  // Data-out line passes two flops before use
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      m1 <= 1'b1;
      m2 <= 1'b1;
    end else begin
      m1 <= link.miso_line;
      m2 <= m1;
    end
  end

  // Pause pin only moves while the clock is low; protect pin follows wp_b_in every cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.hold_b <= 1'b1;
      link.wp_b <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      link.wp_b <= wp_b_in;
      busy_out <= st != HS_IDLE;
      if (st == HS_LOW || st == HS_WAIT) begin
        link.hold_b <= !hold_req_in;
      end else if (st == HS_IDLE) begin
        link.hold_b <= 1'b1;
      end
    end
  end

  // Clock divider and bit sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= HS_IDLE;
      link.sclk <= 1'b0;
      link.cs_b <= 1'b1;
      link.mosi <= 1'b0;
      tmr <= 4'h0;
      bit_idx <= 3'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      last <= 1'b0;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (grab) begin
        link.cs_b <= 1'b0;
        link.mosi <= f_data[7];
        tx_sh <= f_data[7:0];
        last <= f_data[8];
        bit_idx <= 3'h0;
        tmr <= SCLK_HALF_CYC;
        st <= HS_LOW;
      end
      unique case (st)
        HS_IDLE: begin
          link.sclk <= cpol_in;
        end
        HS_LOW: begin
          link.sclk <= 1'b0;
          if (link.hold_b && !hold_req_in) begin
            tmr <= tmr - 4'h1;
            if (tmr_end) begin
              tmr <= SCLK_HALF_CYC;
              st <= HS_HIGH;
            end
          end else begin
            // Full low half after a pause; the far end leaves it late
            tmr <= SCLK_HALF_CYC;
          end
        end
        HS_HIGH: begin
          link.sclk <= 1'b1;
          tmr <= tmr - 4'h1;
          if (tmr_end) begin
            rx_sh <= {rx_sh[6:0], m2};
            bit_idx <= bit_idx + 3'h1;
            tmr <= SCLK_HALF_CYC;
            if (bit_idx == 3'h7) begin
              rx_data_out <= {rx_sh[6:0], m2};
              rx_valid_out <= 1'b1;
              st <= last ? HS_END : HS_WAIT;
            end else begin
              link.mosi <= tx_sh[6];
              tx_sh <= {tx_sh[6:0], 1'b0};
              st <= HS_LOW;
            end
          end
        end
        HS_WAIT: begin
          link.sclk <= 1'b0;
        end
        HS_END: begin
          tmr <= tmr - 4'h1;
          if (tmr_end) begin
            link.sclk <= cpol_in;
            link.cs_b <= 1'b1;
            tmr <= SCLK_HALF_CYC;
            st <= HS_GAP;
          end
        end
        HS_GAP: begin
          tmr <= tmr - 4'h1;
          if (tmr_end) begin
            st <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: hw/sfp_flash_end.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Sample data-in on rising serial clock
// - Change data-out only after falling clock
// - Chip select high: deselected, output released
// - Standby when deselected and no internal cycle
// - Decode only after a chip-select falling edge
// - Pause suspends transfer, resumes where stopped
// - While paused, output released, inputs ignored
// - Pause only honoured while chip select low
// - Write-protect freezes the block-protect bits
// - Modes 0 and 3 only, same edges
// - Either clock idle level is accepted
// - Address space: 32 sectors, 256 pages each
// - Page program takes 1 to 256 bytes
// - Sector erase or whole-array bulk erase
// - Pause edges take effect while clock low
// - Writes execute only on whole-byte clock counts
module sfp_flash_end (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic busy_in,
  input wire logic [7:0] tx_byte_in,
  sfp_link_if.flash link,
  output logic [7:0] op_out,
  output logic [sfp_pkg::ADDR_W-1:0] addr_out,
  output logic [8:0] prog_count_out,
  output logic exec_out,
  output logic reject_out,
  output logic [7:0] wr_data_out,
  output logic [sfp_pkg::ADDR_W-1:0] wr_addr_out,
  output logic wr_valid_out,
  output logic [sfp_pkg::ADDR_W-1:0] rd_addr_out,
  output logic [2:0] block_protect_bits_out,
  output logic standby_out
);
  import sfp_pkg::*;

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sck_d;
  logic cs_d;
  logic armed;
  logic paused;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  sfp_phase_t phase;
  sfp_phase_t next_phase_op;
  logic [7:0] op;
  logic [23:0] addr_sh;
  logic [1:0] addr_cnt;
  logic addr_done;
  logic [7:0] stat_new;
  logic stat_got;
  logic load_pend;
  logic tx_active;
  logic [7:0] tx_shift;
  logic [7:0] wr_off;
  logic [8:0] prog_cnt;
  wire [4:0] pins;
  wire sck, csb, din, holdb, wpb;
  wire rise, fall, cs_fall, cs_rise;
  wire live, take_bit, byte_done, next_paused;
  wire [7:0] rx_byte;
  wire [7:0] status_byte;
  wire needs_addr, addr_fin, want_load, pp_take;
  wire [5:0] prot_low;
  wire prot_hit, is_write, whole, exec_go;

  // Pin decode after synchronisation; only sync2 feeds logic
  assign pins = {link.sclk, link.cs_b, link.mosi, link.hold_b, link.wp_b};
  assign sck = sync2[4];
  assign csb = sync2[3];
  assign din = sync2[2];
  assign holdb = sync2[1];
  assign wpb = sync2[0];
  assign rise = sck & !sck_d;
  assign fall = !sck & sck_d;
  assign cs_fall = !csb & cs_d;
  assign cs_rise = csb & !cs_d;

  // Bit acceptance gated by selection, arming and pause
  assign live = armed & !csb & !paused;
  assign take_bit = live & rise;
  assign byte_done = take_bit & (bit_cnt == 3'h7);
  assign rx_byte = {shift[6:0], din};

  // Pause enters only while the clock is low; it leaves with the clock low or at once on deselect
  assign next_paused = csb ? 1'b0 : (paused ? !(holdb & !sck) : (!holdb & !sck));

  // Command decode
  assign needs_addr = (rx_byte == OP_READ) | (rx_byte == OP_PAGE_PROG) | (rx_byte == OP_SECTOR_ERASE);
  assign next_phase_op = (busy_in && rx_byte != OP_READ_STATUS) ? PH_IGNORE : (needs_addr ? PH_ADDR : PH_DATA);
  assign addr_fin = byte_done & (phase == PH_ADDR) & (addr_cnt == ADDR_LAST);
  assign status_byte = {3'h0, block_protect_bits_out, 1'b0, busy_in};
  assign want_load = byte_done & (((phase == PH_OP) & (rx_byte == OP_READ_STATUS))
                   | (addr_fin & (op == OP_READ))
                   | ((phase == PH_DATA) & ((op == OP_READ) | (op == OP_READ_STATUS))));
  assign pp_take = byte_done & (phase == PH_DATA) & (op == OP_PAGE_PROG);

  // Upper sectors shielded by the block-protect bits
  assign prot_low = (block_protect_bits_out == 3'h0) ? SECT_NONE
                  : (block_protect_bits_out[2:1] == 2'h3) ? 6'h00
                  : SECT_NONE - (6'h01 << (block_protect_bits_out - 3'h1));
  assign prot_hit = {1'b0, addr_sh[ADDR_W-1:SECT_LSB]} >= prot_low;

  // Execute decision at deselect
  assign is_write = (op == OP_PAGE_PROG) | (op == OP_SECTOR_ERASE) | (op == OP_BULK_ERASE) | (op == OP_WRITE_STATUS);
  assign whole = bit_cnt == 3'h0;
  assign exec_go = cs_rise & armed & (phase != PH_OP) & whole & !busy_in & (
                   ((op == OP_PAGE_PROG) & addr_done & (prog_cnt != 9'h000) & !prot_hit)
                 | ((op == OP_SECTOR_ERASE) & addr_done & !prot_hit)
                 | ((op == OP_BULK_ERASE) & (block_protect_bits_out == 3'h0))
                 | ((op == OP_WRITE_STATUS) & stat_got & wpb));

  // Synchronisers; cs resets low so a pin held low gives no edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= PIN_RESET;
      sync2 <= PIN_RESET;
      sck_d <= 1'b0;
      cs_d <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sck_d <= sck;
      cs_d <= csb;
    end
  end

  // Arming on first select edge, pause tracking, standby
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed <= 1'b0;
      paused <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      if (cs_fall) begin
        armed <= 1'b1;
      end
      paused <= next_paused;
      standby_out <= csb & !busy_in;
    end
  end

  // Input shifter; bit count survives a pause
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt <= 3'h0;
      shift <= 8'h00;
    end else if (csb) begin
      bit_cnt <= 3'h0;
    end else if (take_bit) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= rx_byte;
    end
  end

  // Frame phases: opcode, three address bytes, data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase <= PH_OP;
      op <= 8'h00;
      addr_sh <= 24'h000000;
      addr_cnt <= 2'h0;
      addr_done <= 1'b0;
      stat_new <= 8'h00;
      stat_got <= 1'b0;
    end else if (csb) begin
      phase <= PH_OP;
      addr_cnt <= 2'h0;
      addr_done <= 1'b0;
      stat_got <= 1'b0;
    end else if (byte_done) begin
      unique case (phase)
        PH_OP: begin
          op <= rx_byte;
          phase <= next_phase_op;
        end
        PH_ADDR: begin
          addr_sh <= {addr_sh[15:0], rx_byte};
          addr_cnt <= addr_cnt + 2'h1;
          if (addr_fin) begin
            phase <= PH_DATA;
            addr_done <= 1'b1;
          end
        end
        PH_DATA: begin
          if (op == OP_WRITE_STATUS && !stat_got) begin
            stat_new <= rx_byte;
            stat_got <= 1'b1;
          end
        end
        PH_IGNORE: begin
        end
      endcase
    end
  end

  // Output shifter: load between bytes, launch on falling edges
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      load_pend <= 1'b0;
      tx_active <= 1'b0;
      tx_shift <= 8'h00;
      link.miso <= 1'b0;
      link.miso_oe <= 1'b0;
    end else begin
      load_pend <= want_load;
      link.miso_oe <= tx_active & live;
      if (csb) begin
        tx_active <= 1'b0;
      end else if (load_pend) begin
        tx_shift <= (op == OP_READ_STATUS) ? status_byte : tx_byte_in;
        tx_active <= 1'b1;
      end else if (live && fall && tx_active) begin
        link.miso <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Read address: loaded from the frame, stepped per byte sent
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_addr_out <= '0;
    end else if (addr_fin && op == OP_READ) begin
      rd_addr_out <= {addr_sh[ADDR_W-9:0], rx_byte};
    end else if (load_pend && op == OP_READ) begin
      rd_addr_out <= rd_addr_out + ADDR_W'(1);
    end
  end

  // Program data stream; offset wraps inside the page
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_off <= 8'h00;
      prog_cnt <= 9'h000;
      wr_data_out <= 8'h00;
      wr_addr_out <= '0;
      wr_valid_out <= 1'b0;
    end else begin
      wr_valid_out <= pp_take;
      if (addr_fin) begin
        wr_off <= rx_byte;
        prog_cnt <= 9'h000;
      end else if (pp_take) begin
        wr_data_out <= rx_byte;
        wr_addr_out <= {addr_sh[ADDR_W-1:PAGE_LSB], wr_off};
        wr_off <= wr_off + 8'h01;
        if (prog_cnt != PROG_MAX) begin
          prog_cnt <= prog_cnt + 9'h001;
        end
      end
    end
  end

  // Commit or refuse a write-class frame at deselect
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      exec_out <= 1'b0;
      reject_out <= 1'b0;
      op_out <= 8'h00;
      addr_out <= '0;
      prog_count_out <= 9'h000;
      block_protect_bits_out <= BP_RESET;
    end else begin
      exec_out <= exec_go;
      reject_out <= cs_rise & armed & (phase != PH_OP) & is_write & !exec_go;
      if (exec_go) begin
        op_out <= op;
        addr_out <= addr_sh[ADDR_W-1:0];
        prog_count_out <= prog_cnt;
        if (op == OP_WRITE_STATUS) begin
          block_protect_bits_out <= stat_new[4:2];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/sfp_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sfp_link_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic hold_b,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic cpol_in
);
  logic [2:0] bits;
  logic [3:0] since_fall;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Rising clock count of the open frame, modulo one byte
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bits <= 3'h0;
    end else begin
      bits <= cs_b ? 3'h0 : bits + 3'($rose(sclk));
    end
  end

  // Age of the last falling clock, saturating so it never wraps
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_fall <= 4'hf;
    end else begin
      since_fall <= $fell(sclk) ? 4'h0 : (since_fall == 4'hf ? since_fall : since_fall + 4'h1);
    end
  end

  // Output release and launch edges
  property p_desel_release;
    cs_b [*6] |-> !miso_oe;
  endproperty
  a_desel_release: assert property (p_desel_release) else $error("data out driven while deselected");
  property p_pause_release;
    !hold_b [*6] |-> !miso_oe;
  endproperty
  a_pause_release: assert property (p_pause_release) else $error("data out driven while paused");
  property p_out_after_fall;
    $changed(miso) && miso_oe && $past(miso_oe) |-> since_fall < 4'h6;
  endproperty
  a_out_after_fall: assert property (p_out_after_fall) else $error("data out moved without a falling clock");
  property p_oe_start;
    $rose(miso_oe) |-> !cs_b && hold_b;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("data out enabled while idle or paused");

  // Master side of the wire
  property p_idle_clock;
    cs_b && $past(cs_b) && $past(rst_b_in, 2) |-> sclk == $past(cpol_in);
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock moved while deselected");
  property p_pause_selected;
    !hold_b |-> !cs_b;
  endproperty
  a_pause_selected: assert property (p_pause_selected) else $error("pause while deselected");
  property p_pause_edge;
    $changed(hold_b) |-> !sclk;
  endproperty
  a_pause_edge: assert property (p_pause_edge) else $error("pause edge with clock high");
  property p_pause_frozen;
    !hold_b && $past(!hold_b) |-> $stable(sclk) && $stable(mosi);
  endproperty
  a_pause_frozen: assert property (p_pause_frozen) else $error("link moved during pause");
  property p_data_setup;
    $rose(sclk) |-> $stable(mosi);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data in moved at rising clock");
  property p_whole_bytes;
    $rose(cs_b) |-> bits == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not a whole number of bytes");

  c_pause: cover property ($fell(hold_b));
  c_read_out: cover property ($rose(miso_oe));
  c_frame: cover property ($rose(cs_b));
endmodule
`default_nettype wire

// file: testbench/serial_flash_spi_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_spi_port_tb;
  import sfp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cpol = 1'b0, hold_req = 1'b0, wp_b = 1'b1, fbusy = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0, tx_valid = 1'b0;
  logic tx_ready, rx_valid, busy, exec, rej, wr_valid, standby, exec2, rej2;
  logic [7:0] rx_data, op, wr_data, wop;
  logic [ADDR_W-1:0] addr, rd_addr, addr2, wr_addr;
  logic [8:0] cnt;
  logic [2:0] bp;
  logic [7:0] q[$], rx[$];
  int n_errors = 0, n_checks = 0, n_ex = 0, n_rj = 0, n_wr = 0, n_ex2 = 0, n_rj2 = 0, n_bit = 0, saw_full = 0;
  // Array contents seen by reads
  wire [7:0] tx_byte = rd_addr[7:0] ^ 8'h5a;
  sfp_link_if l1();
  sfp_link_if l2();

  sfp_master_end u_sfp_master_end (.clk_in(clk_in), .rst_b_in(rst_b_in), .cpol_in(cpol), .hold_req_in(hold_req),
    .wp_b_in(wp_b), .tx_data_in(tx_data), .tx_last_in(tx_last), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .busy_out(busy), .link(l1.master));
  sfp_flash_end u_sfp_flash_end (.clk_in(clk_in), .rst_b_in(rst_b_in), .busy_in(fbusy), .tx_byte_in(tx_byte),
    .link(l1.flash), .op_out(op), .addr_out(addr), .prog_count_out(cnt), .exec_out(exec), .reject_out(rej),
    .wr_data_out(wr_data), .wr_addr_out(wr_addr), .wr_valid_out(wr_valid), .rd_addr_out(rd_addr),
    .block_protect_bits_out(bp), .standby_out(standby));
  // Second flash end, its link driven by hand to break the master's rules
  sfp_flash_end u_sfp_flash_end_b (.clk_in(clk_in), .rst_b_in(rst_b_in), .busy_in(1'b0), .tx_byte_in(8'h00),
    .link(l2.flash), .op_out(), .addr_out(addr2), .prog_count_out(), .exec_out(exec2), .reject_out(rej2),
    .wr_data_out(), .wr_addr_out(), .wr_valid_out(), .rd_addr_out(), .block_protect_bits_out(), .standby_out());
  sfp_link_monitor u_sfp_link_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk(l1.sclk), .cs_b(l1.cs_b),
    .mosi(l1.mosi), .hold_b(l1.hold_b), .miso(l1.miso), .miso_oe(l1.miso_oe), .cpol_in(cpol));

  always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  // Tallies of one-cycle pulses and queue back-pressure
  always @(posedge clk_in) begin
    n_ex += (exec === 1'b1);
    n_rj += (rej === 1'b1);
    n_wr += (wr_valid === 1'b1);
    n_ex2 += (exec2 === 1'b1);
    n_rj2 += (rej2 === 1'b1);
    if (rx_valid === 1'b1) rx.push_back(rx_data);
    if (tx_ready === 1'b0) saw_full = 1;
  end

  // First byte and bit count as seen on the wire
  always @(negedge l1.cs_b) n_bit = 0;
  always @(posedge l1.sclk) begin
    if (l1.cs_b === 1'b0) begin
      if (n_bit < 8) wop = {wop[6:0], l1.mosi};
      n_bit++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hdr(input logic [7:0] o, input logic [23:0] a);
    q = {o, a[23:16], a[15:8], a[7:0]};
  endtask

  // Sends q as one frame; res is {executed, refused}
  task automatic run(input logic [1:0] res);
    int e0, r0, t;
    logic ok;
    e0 = n_ex;
    r0 = n_rj;
    rx = {};
    foreach (q[i]) begin
      tx_data = q[i];
      tx_last = (i == q.size() - 1);
      tx_valid = 1'b1;
      do begin
        @(posedge clk_in);
        ok = tx_ready;
        #1;
      end while (ok !== 1'b1);
    end
    tx_valid = 1'b0;
    t = 0;
    do @(posedge clk_in); while (busy !== 1'b0 || t++ < 4);
    repeat (10) @(posedge clk_in);
    #1;
    chk({n_ex - e0 == 1, n_rj - r0 == 1}, res);
    chk(wop, q[0]);
    chk(n_bit, 8 * q.size());
    chk(l1.sclk, cpol);
  endtask

  // Hand-made link clock, free of the system clock's phase
  task automatic bb(input logic [39:0] v, input int n);
    for (int i = 39; i > 39 - n; i--) begin
      l2.mosi = v[i];
      #(SCLK_PERIOD_NS / 2) l2.sclk = 1'b1;
      #(SCLK_PERIOD_NS / 2) l2.sclk = 1'b0;
    end
  endtask

  initial begin
    #800000;
    n_errors++;
    end_of_test;
  end

  initial begin
    int s, w0;
    l2.sclk = 1'b0;
    l2.cs_b = 1'b0;
    l2.mosi = 1'b0;
    l2.hold_b = 1'b1;
    l2.wp_b = 1'b1;
    repeat (16) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    chk(standby, 1'b1);
    chk(bp, BP_RESET);
    chk(l1.miso_line, 1'b1);
    // Protected boundary sector for protect settings 1 to 6
    for (int b = 1; b < 7; b++) begin
      q = {OP_WRITE_STATUS, 8'(b << 2)};
      run(2'b10);
      chk(bp, b);
      s = (b == 6) ? 0 : 32 - (1 << (b - 1));
      hdr(OP_SECTOR_ERASE, 24'(s) << 16);
      run(2'b01);
      if (b < 6) begin
        hdr(OP_SECTOR_ERASE, 24'(s - 1) << 16);
        run(2'b10);
        chk(addr, 21'(s - 1) << 16);
      end
    end
    q = {OP_BULK_ERASE};
    run(2'b01);
    q = {OP_READ_STATUS, 8'h00};
    run(2'b00);
    chk(rx[1], 8'h18);
    // Write protect freezes the protect bits
    wp_b = 1'b0;
    q = {OP_WRITE_STATUS, 8'h00};
    run(2'b01);
    chk(bp, 3'h6);
    wp_b = 1'b1;
    run(2'b10);
    chk(bp, 3'h0);
    q = {OP_BULK_ERASE};
    run(2'b10);
    chk(op, OP_BULK_ERASE);
    // Full page into the last page, overrunning the byte queue
    hdr(OP_PAGE_PROG, 24'h1fff00);
    for (int i = 0; i < 256; i++) q.push_back(8'(i));
    w0 = n_wr;
    run(2'b10);
    chk(cnt, PROG_MAX);
    chk(n_wr - w0, 256);
    chk(wr_data, 8'hff);
    chk(saw_full, 1);
    chk(addr, 21'h1fff00);
    chk(wr_addr, 21'h1fffff);
    hdr(OP_PAGE_PROG, 24'h000005);
    q.push_back(8'h3c);
    run(2'b10);
    chk(cnt, 9'h001);
    chk(wr_data, 8'h3c);
    chk(wr_addr, 21'h000005);
    hdr(OP_PAGE_PROG, 24'h000005);
    run(2'b01);
    // Internal cycle running: refused and no standby
    fbusy = 1'b1;
    hdr(OP_SECTOR_ERASE, 24'h000000);
    run(2'b01);
    chk(standby, 1'b0);
    fbusy = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk(standby, 1'b1);
    // Read across the top of the array
    hdr(OP_READ, 24'h1ffffe);
    q = {q, 8'h00, 8'h00, 8'h00};
    run(2'b00);
    chk(rx[4], 8'ha4);
    chk(rx[5], 8'ha5);
    chk(rx[6], 8'h5a);
    // Clock idling high, read paused in a data byte
    cpol = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    hdr(OP_READ, 24'h000010);
    q = {q, 8'h00, 8'h00};
    fork
      run(2'b00);
      begin
        repeat (350) @(posedge clk_in);
        #1 hold_req = 1'b1;
        repeat (20) @(posedge clk_in);
        #1;
        chk(l1.hold_b, 1'b0);
        chk(l1.miso_oe, 1'b0);
        chk(l1.sclk, 1'b0);
        hold_req = 1'b0;
      end
    join
    chk(rx[4], 8'h4a);
    chk(rx[5], 8'h4b);
    // Hand-driven end: no select edge, odd count, then a good frame
    bb({OP_SECTOR_ERASE, 24'h010000, 8'h00}, 32);
    #40 l2.cs_b = 1'b1;
    l2.mosi = ~l2.mosi;
    #500;
    chk(n_ex2 + n_rj2, 0);
    l2.cs_b = 1'b0;
    #40 bb({OP_SECTOR_ERASE, 24'h010000, 8'h00}, 33);
    #40 l2.cs_b = 1'b1;
    l2.mosi = ~l2.mosi;
    #500;
    chk(n_rj2, 1);
    l2.cs_b = 1'b0;
    #40 bb({OP_SECTOR_ERASE, 24'h010000, 8'h00}, 32);
    #40 l2.cs_b = 1'b1;
    #500;
    chk(n_ex2, 1);
    chk(addr2, 21'h010000);
    end_of_test;
  end
endmodule
`default_nettype wire
